// ### hw/tqch_map.svh
// constants of the torque compare and hold block: limits, timing, reset values
// assumes a single 25 MHz system clock
`ifndef TQCH_MAP_SVH
`define TQCH_MAP_SVH

// ----------------------------------------
// clock and hold timing
// ----------------------------------------
`define TQCH_CLK_NS 40
`define TQCH_T_HOLD_NS 1000000

// ----------------------------------------
// signed limit range of the timing window
// ----------------------------------------
`define TQCH_LIM_MAX 18'sh1869f
`define TQCH_LIM_MIN (-18'sh1869f)

// ----------------------------------------
// reset values
// ----------------------------------------
`define TQCH_TIM_HI_RST `TQCH_LIM_MAX
`define TQCH_TIM_LO_RST `TQCH_LIM_MIN
`define TQCH_CMP_RST 1'b0
`define TQCH_VAL_RST 18'sh00000

`endif

// ### hw/tqch_pkg.sv
// types of the torque compare and hold block
// assumes the constants of tqch_map.svh
package tqch_pkg;

	typedef enum logic [2:0] {
		TQCH_HM_OFF = 3'h0,
		TQCH_HM_SAMPLE = 3'h1,
		TQCH_HM_PEAK = 3'h2,
		TQCH_HM_BOTTOM = 3'h3,
		TQCH_HM_PP = 3'h4,
		TQCH_HM_AVG = 3'h5,
		TQCH_HM_ANGLE = 3'h6
	} tqch_hold_mode_t;

	typedef enum logic [1:0] {
		TQCH_SEC_WHOLE = 2'h0,
		TQCH_SEC_EXT = 2'h1,
		TQCH_SEC_EXT_TIME = 2'h2,
		TQCH_SEC_LVL_TIME = 2'h3
	} tqch_sect_t;

	typedef enum logic [2:0] {
		TQCH_CT_ALL = 3'h0,
		TQCH_CT_STABLE = 3'h1,
		TQCH_CT_NZ_OFF = 3'h2,
		TQCH_CT_STABLE_NZ = 3'h3,
		TQCH_CT_HOLD = 3'h4
	} tqch_cmp_time_t;

	typedef enum logic [2:0] {
		TQCH_ST_TRACK = 3'h1,
		TQCH_ST_DETECT = 3'h2,
		TQCH_ST_DECIDED = 3'h4
	} tqch_hold_st_t;

endpackage

// ### hw/tqch_sync.sv
// two-stage synchroniser for external control pins
// assumes inputs asynchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module tqch_sync #(
	parameter int W = 2
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// pins in, synchronised levels out
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_ff;

	// ----------------------------------------
	// one pair of flops per bit
	// ----------------------------------------
	// first stage feeds only the second stage
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				meta_ff[i] <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				meta_ff[i] <= pin_in[i];
				sync_out[i] <= meta_ff[i];
			end
		end
	end

endmodule
`default_nettype wire

// ### hw/tqch_limit_cmp.sv
// HI/OK/LO limit comparator with registered, held results
// assumes value and limits on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "tqch_map.svh"
module tqch_limit_cmp #(
	parameter int VW = 18
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// value, limits and evaluate strobe
	input wire logic signed [VW-1:0] value,
	input wire logic signed [VW-1:0] hi_lim,
	input wire logic signed [VW-1:0] lo_lim,
	input wire logic evaluate,
	// judgement
	output logic hi_ff,
	output logic ok_ff,
	output logic lo_ff
);

	logic nxt_hi, nxt_ok, nxt_lo;

	always_comb begin
		nxt_hi = hi_ff;
		nxt_ok = ok_ff;
		nxt_lo = lo_ff;
		// skipped evaluations keep the last judgement
		if (evaluate) begin
			nxt_hi = value > hi_lim;
			nxt_lo = value < lo_lim;
			nxt_ok = !(value > hi_lim) && !(value < lo_lim);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hi_ff <= `TQCH_CMP_RST;
			ok_ff <= `TQCH_CMP_RST;
			lo_ff <= `TQCH_CMP_RST;
		end else begin
			hi_ff <= nxt_hi;
			ok_ff <= nxt_ok;
			lo_ff <= nxt_lo;
		end
	end

endmodule
`default_nettype wire

// ### hw/tqch_top.sv
// torque compare and hold: comparison gating, timing/sign output, torque hold
// assumes indicated values and status flags arrive from logic on sys_clk;
// track/hold and section come from pins and are synchronised here
//
// Summary of operation
// - timing 0: compare torque on every value
// - timing 1: compare only while stable
// - timing 3: stable and near-zero off
// - timing 4: compare only when hold decided
// - speed compare continuous or torque-gated
// - second aux: timing or negative sign
// - timing output: live torque inside window
// - window limits span -99999 to 99999
// - hold mode codes 0 to 6
// - sample hold: whole or external section
// - peak/bottom holds: whole or external section; timer methods act as external
// - sample holds value at section start
// - peak holds most positive value
// - bottom holds most negative value
// - whole section: held within 1.0ms
// - release returns to tracking within 1.0ms
// - section start begins detection within 1.0ms
// - section end decides hold within 1.0ms
// - undetermined section: judge follows, end flag on
// - HI above, LO below, else OK
`timescale 1ns/100ps
`default_nettype none
`include "tqch_map.svh"
module tqch_top #(
	parameter int VW = 18,
	parameter int unsigned HOLD_RST_CYC = (`TQCH_T_HOLD_NS + `TQCH_CLK_NS - 1) / `TQCH_CLK_NS
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// measurement stream
	input wire logic signed [VW-1:0] torque_value,
	input wire logic torque_valid,
	input wire logic signed [VW-1:0] speed_value,
	input wire logic speed_valid,
	input wire logic stable_flag,
	input wire logic near_zero,
	// external control pins
	input wire logic track_hold_pin,
	input wire logic section_pin,
	// settings
	input wire tqch_pkg::tqch_cmp_time_t torque_cmp_timing,
	input wire logic speed_cmp_sync,
	input wire logic aux_sel_sign,
	input wire logic abs_marked,
	input wire tqch_pkg::tqch_hold_mode_t hold_mode,
	input wire tqch_pkg::tqch_sect_t section_method,
	// limits
	input wire logic signed [VW-1:0] torque_hi_lim,
	input wire logic signed [VW-1:0] torque_lo_lim,
	input wire logic signed [VW-1:0] speed_hi_lim,
	input wire logic signed [VW-1:0] speed_lo_lim,
	input wire logic signed [VW-1:0] timing_hi_lim,
	input wire logic signed [VW-1:0] timing_lo_lim,
	// judgement
	output logic torque_hi,
	output logic torque_ok,
	output logic torque_lo,
	output logic speed_hi,
	output logic speed_ok,
	output logic speed_lo,
	output logic aux_output_second,
	// hold status and indicated value
	output logic hold_end,
	output logic hold_decided,
	output logic signed [VW-1:0] indicated_value
);
	import tqch_pkg::*;

	localparam int CW = $clog2(HOLD_RST_CYC + 1);

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	logic [1:0] pins_sync;
	logic th_lvl, sec_lvl;

	tqch_sync #(
		.W(2)
	) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in({section_pin, track_hold_pin}),
		.sync_out(pins_sync)
	);

	assign th_lvl = pins_sync[0];
	assign sec_lvl = pins_sync[1];

	// ----------------------------------------
	// setting decode
	// ----------------------------------------
	logic hold_on, use_ext;
	logic signed [VW-1:0] tim_hi, tim_lo;

	// pp, average and angle holds are not built here; they behave as off
	always_comb begin
		unique case (hold_mode)
			TQCH_HM_SAMPLE, TQCH_HM_PEAK, TQCH_HM_BOTTOM: hold_on = 1'b1;
			default: hold_on = 1'b0;
		endcase
		// sample knows only whole and external sections
		if (hold_mode == TQCH_HM_SAMPLE) begin
			use_ext = section_method == TQCH_SEC_EXT;
		end else begin
			// timer-based sections fall back to the plain external section
			use_ext = section_method != TQCH_SEC_WHOLE;
		end
		// a high window limit above the span and a low limit below it are clamped to its ends
		tim_hi = timing_hi_lim > `TQCH_LIM_MAX ? `TQCH_LIM_MAX : timing_hi_lim;
		tim_lo = timing_lo_lim < `TQCH_LIM_MIN ? `TQCH_LIM_MIN : timing_lo_lim;
	end

	// ----------------------------------------
	// hold state machine
	// ----------------------------------------
	tqch_hold_st_t st_ff, nxt_st;
	logic th_d_ff, nxt_th_d, sec_d_ff, nxt_sec_d;
	logic [CW-1:0] rst_cnt_ff, nxt_rst_cnt;
	logic signed [VW-1:0] hold_val_ff, nxt_hold_val;
	logic th_rise, th_fall, sec_rise, sec_fall, rst_done;

	assign th_rise = th_lvl && !th_d_ff;
	assign th_fall = !th_lvl && th_d_ff;
	assign sec_rise = sec_lvl && !sec_d_ff;
	assign sec_fall = !sec_lvl && sec_d_ff;
	assign rst_done = rst_cnt_ff == CW'(HOLD_RST_CYC);

	always_comb begin
		nxt_st = st_ff;
		nxt_th_d = th_lvl;
		nxt_sec_d = sec_lvl;
		nxt_hold_val = hold_val_ff;
		nxt_rst_cnt = '0;
		// a hold reset counts only while track/hold stays high
		if (th_lvl && !rst_done) begin
			nxt_rst_cnt = rst_cnt_ff + CW'(1);
		end else if (th_lvl) begin
			nxt_rst_cnt = rst_cnt_ff;
		end
		unique case (st_ff)
			TQCH_ST_TRACK: begin
				nxt_hold_val = torque_value;
				if (hold_on && ((!use_ext && th_lvl) || (use_ext && sec_rise))) begin
					nxt_st = TQCH_ST_DETECT;
				end
			end
			TQCH_ST_DETECT: begin
				if (torque_valid) begin
					if (hold_mode == TQCH_HM_PEAK && torque_value > hold_val_ff) begin
						nxt_hold_val = torque_value;
					end
					if (hold_mode == TQCH_HM_BOTTOM && torque_value < hold_val_ff) begin
						nxt_hold_val = torque_value;
					end
				end
				// sample keeps the value caught on entry
				if (!hold_on) begin
					nxt_st = TQCH_ST_TRACK;
				end else if (!use_ext && !th_lvl) begin
					nxt_st = TQCH_ST_TRACK;
				end else if (use_ext && sec_fall) begin
					nxt_st = TQCH_ST_DECIDED;
				end
			end
			TQCH_ST_DECIDED: begin
				if (!hold_on || !use_ext) begin
					nxt_st = TQCH_ST_TRACK;
				end else if (sec_rise) begin
					// new section restarts detection without a reset
					nxt_st = TQCH_ST_DETECT;
					nxt_hold_val = torque_value;
				end else if (th_lvl && rst_done) begin
					nxt_st = TQCH_ST_TRACK;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_ff <= TQCH_ST_TRACK;
			th_d_ff <= 1'b0;
			sec_d_ff <= 1'b0;
			rst_cnt_ff <= '0;
			hold_val_ff <= `TQCH_VAL_RST;
		end else begin
			st_ff <= nxt_st;
			th_d_ff <= nxt_th_d;
			sec_d_ff <= nxt_sec_d;
			rst_cnt_ff <= nxt_rst_cnt;
			hold_val_ff <= nxt_hold_val;
		end
	end

	// ----------------------------------------
	// indicated value and hold flags
	// ----------------------------------------
	logic signed [VW-1:0] nxt_ind;
	logic nxt_he, nxt_dec, is_decided;
	logic ind_valid_ff, nxt_ind_valid;

	// whole section has no deciding phase; a held value counts as decided
	assign is_decided = (st_ff == TQCH_ST_DECIDED) || (st_ff == TQCH_ST_DETECT && !use_ext);

	always_comb begin
		// shows the next hold value, so the judge one cycle on never misses the newest sample
		nxt_ind = st_ff == TQCH_ST_TRACK ? torque_value : nxt_hold_val;
		nxt_he = st_ff != TQCH_ST_TRACK;
		nxt_dec = is_decided;
		nxt_ind_valid = torque_valid;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			indicated_value <= `TQCH_VAL_RST;
			hold_end <= 1'b0;
			hold_decided <= 1'b0;
			ind_valid_ff <= 1'b0;
		end else begin
			indicated_value <= nxt_ind;
			hold_end <= nxt_he;
			hold_decided <= nxt_dec;
			ind_valid_ff <= nxt_ind_valid;
		end
	end

	// ----------------------------------------
	// comparison gating
	// ----------------------------------------
	logic gate, torque_eval, speed_eval;

	always_comb begin
		unique case (torque_cmp_timing)
			TQCH_CT_ALL: gate = 1'b1;
			TQCH_CT_STABLE: gate = stable_flag;
			TQCH_CT_NZ_OFF: gate = !near_zero;
			TQCH_CT_STABLE_NZ: gate = stable_flag && !near_zero;
			TQCH_CT_HOLD: gate = hold_decided;
			default: gate = 1'b1;
		endcase
		// judged against the indicated value, one cycle after it updates
		torque_eval = ind_valid_ff && gate;
		speed_eval = speed_valid && (!speed_cmp_sync || gate);
	end

	tqch_limit_cmp #(
		.VW(VW)
	) u_tq_cmp (
		.sys_clk(sys_clk),
		.rst(rst),
		.value(indicated_value),
		.hi_lim(torque_hi_lim),
		.lo_lim(torque_lo_lim),
		.evaluate(torque_eval),
		.hi_ff(torque_hi),
		.ok_ff(torque_ok),
		.lo_ff(torque_lo)
	);

	tqch_limit_cmp #(
		.VW(VW)
	) u_sp_cmp (
		.sys_clk(sys_clk),
		.rst(rst),
		.value(speed_value),
		.hi_lim(speed_hi_lim),
		.lo_lim(speed_lo_lim),
		.evaluate(speed_eval),
		.hi_ff(speed_hi),
		.ok_ff(speed_ok),
		.lo_ff(speed_lo)
	);

	// ----------------------------------------
	// timing window and second aux output
	// ----------------------------------------
	logic tim_ff, nxt_tim, nxt_aux;

	always_comb begin
		nxt_tim = tim_ff;
		// uses live torque; the hold never affects the window
		if (torque_valid) begin
			nxt_tim = torque_value >= tim_lo && torque_value <= tim_hi;
		end
		// sign mark needs the marked absolute display to be chosen
		nxt_aux = aux_sel_sign ? (torque_value < 0 && abs_marked) : nxt_tim;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tim_ff <= 1'b0;
			aux_output_second <= 1'b0;
		end else begin
			tim_ff <= nxt_tim;
			aux_output_second <= nxt_aux;
		end
	end

endmodule
`default_nettype wire

// ### sim/tqch_top_props.sv
// checker for tqch_top: judgement, gating, aux output, hold timing
// assumes one clock domain, bound to every tqch_top instance
`timescale 1ns/100ps
`default_nettype none
module tqch_top_props (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// inputs
	input wire logic signed [17:0] torque_value,
	input wire logic torque_valid,
	input wire logic signed [17:0] speed_value,
	input wire logic speed_valid,
	input wire logic stable_flag,
	input wire logic track_hold_pin,
	input wire tqch_pkg::tqch_cmp_time_t torque_cmp_timing,
	input wire logic speed_cmp_sync,
	input wire logic aux_sel_sign,
	input wire logic abs_marked,
	input wire tqch_pkg::tqch_hold_mode_t hold_mode,
	input wire tqch_pkg::tqch_sect_t section_method,
	input wire logic signed [17:0] torque_hi_lim,
	input wire logic signed [17:0] torque_lo_lim,
	input wire logic signed [17:0] speed_hi_lim,
	input wire logic signed [17:0] speed_lo_lim,
	input wire logic signed [17:0] timing_hi_lim,
	input wire logic signed [17:0] timing_lo_lim,
	// outputs
	input wire logic torque_hi,
	input wire logic torque_ok,
	input wire logic torque_lo,
	input wire logic speed_hi,
	input wire logic speed_ok,
	input wire logic speed_lo,
	input wire logic aux_output_second,
	input wire logic hold_end,
	input wire logic hold_decided,
	input wire logic signed [17:0] indicated_value
);
	import tqch_pkg::*;
	wire logic [2:0] tj = {torque_hi, torque_ok, torque_lo};
	wire logic [2:0] sj = {speed_hi, speed_ok, speed_lo};
	wire logic whl = section_method == TQCH_SEC_WHOLE && hold_mode inside {TQCH_HM_SAMPLE, TQCH_HM_PEAK, TQCH_HM_BOTTOM};
	// ok drops when either limit is crossed
	function automatic logic [2:0] jdg(input logic signed [17:0] v, h, l);
		return {v > h, !(v > h) && !(v < l), v < l};
	endfunction
	default clocking dcb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ----
	// assertions
	// ----
	chk_torque_judge: assert property (torque_cmp_timing == TQCH_CT_ALL && $past(torque_valid)
		|=> tj == jdg($past(indicated_value), $past(torque_hi_lim), $past(torque_lo_lim))) else $error("torque judge");
	chk_stable_gate: assert property (torque_cmp_timing == TQCH_CT_STABLE && !stable_flag
		|=> $stable(tj)) else $error("torque judge moved while unstable");
	chk_hold_gate: assert property (torque_cmp_timing == TQCH_CT_HOLD && !hold_decided
		|=> $stable(tj)) else $error("torque judge moved before hold decided");
	chk_speed_judge: assert property (speed_valid && !speed_cmp_sync
		|=> sj == jdg($past(speed_value), $past(speed_hi_lim), $past(speed_lo_lim))) else $error("speed judge");
	chk_speed_gated: assert property (speed_cmp_sync && torque_cmp_timing == TQCH_CT_STABLE && !stable_flag
		|=> $stable(sj)) else $error("speed judge moved while torque gate closed");
	chk_window_out: assert property (torque_valid && !aux_sel_sign |=> aux_output_second ==
		($past(torque_value) >= $past(timing_lo_lim) && $past(torque_value) <= $past(timing_hi_lim))) else $error("window");
	chk_sign_out: assert property (aux_sel_sign
		|=> aux_output_second == ($past(torque_value) < 0 && $past(abs_marked))) else $error("sign output");
	chk_hold_rise: assert property (whl && $rose(track_hold_pin) |-> ##[1:4] hold_end) else $error("hold late");
	chk_hold_fall: assert property (whl && $fell(track_hold_pin) |-> ##[1:4] !hold_end) else $error("track late");
	cov_decided: cover property (torque_cmp_timing == TQCH_CT_HOLD && $rose(hold_decided));
	cov_sign_on: cover property (aux_sel_sign && aux_output_second);
	cov_window_on: cover property (!aux_sel_sign && torque_valid && aux_output_second);
endmodule
bind tqch_top tqch_top_props u_props (.*);
`default_nettype wire

// ### sim/tqch_stream_model.sv
// measurement stream model: torque and speed samples with a one-cycle valid
// assumes the bench calls send from a single process
`timescale 1ns/100ps
`default_nettype none
module tqch_stream_model (
	// clock
	input wire logic sys_clk,
	// stream
	output logic signed [17:0] torque_value,
	output logic torque_valid,
	output logic signed [17:0] speed_value,
	output logic speed_valid
);
	initial begin
		torque_value = 18'sh00000;
		speed_value = 18'sh00000;
		torque_valid = 1'b0;
		speed_valid = 1'b0;
	end
	// idle bus shows the inverse, so stale data never passes as fresh
	task automatic send(input logic signed [17:0] tv, input logic signed [17:0] sv);
		@(negedge sys_clk);
		torque_value = tv;
		speed_value = sv;
		torque_valid = 1'b1;
		speed_valid = 1'b1;
		@(negedge sys_clk);
		torque_value = ~tv;
		speed_value = ~sv;
		torque_valid = 1'b0;
		speed_valid = 1'b0;
		@(negedge sys_clk);
	endtask
endmodule
`default_nettype wire

// ### sim/tqch_top_tb.sv
// self-checking bench for tqch_top: gating, judgement, aux output, holds
// assumes tqch_stream_model feeds the stream, hold reset shortened to 8 cycles
`timescale 1ns/100ps
`default_nettype none
module tqch_top_tb;
	import tqch_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic stable_flag = 1'b0, near_zero = 1'b0, track_hold_pin = 1'b0, section_pin = 1'b0;
	logic speed_cmp_sync = 1'b0, aux_sel_sign = 1'b0, abs_marked = 1'b0;
	tqch_cmp_time_t torque_cmp_timing = TQCH_CT_ALL;
	tqch_hold_mode_t hold_mode = TQCH_HM_OFF;
	tqch_sect_t section_method = TQCH_SEC_WHOLE;
	logic signed [17:0] torque_hi_lim = 18'sh003e8, torque_lo_lim = -18'sh003e8;
	logic signed [17:0] speed_hi_lim = 18'sh005dc, speed_lo_lim = 18'sh00064;
	logic signed [17:0] timing_hi_lim = 18'sh1869f, timing_lo_lim = -18'sh1869f;
	logic signed [17:0] torque_value, speed_value, indicated_value, hv, lv;
	logic torque_valid, speed_valid, torque_hi, torque_ok, torque_lo, speed_hi, speed_ok, speed_lo;
	logic aux_output_second, hold_end, hold_decided, hold = 1'b0, hd = 1'b0;
	logic [2:0] lastj = 3'h0;
	logic [2:0] vd = 3'h0;
	logic [3:0] q[$];
	logic signed [17:0] bv[8];
	int errors = 0, samples_checked = 0, s;
	tqch_hold_mode_t hm[3] = '{TQCH_HM_SAMPLE, TQCH_HM_PEAK, TQCH_HM_BOTTOM};
	tqch_top #(.HOLD_RST_CYC(8)) uut (.*);
	tqch_stream_model m (.*);
	initial forever #20 sys_clk = ~sys_clk;
	// ----
	// helpers
	// ----
	function automatic logic [2:0] jdg(input logic signed [17:0] v);
		return {v > torque_hi_lim, !(v > torque_hi_lim) && !(v < torque_lo_lim), v < torque_lo_lim};
	endfunction
	task automatic chk(input string n, input logic [17:0] e, input logic [17:0] sv);
		samples_checked++;
		if (sv !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, sv);
		end
	endtask
	task automatic results();
		if (errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// notes the expected judgement and aux level, then sends the sample
	task automatic put(input logic signed [17:0] v);
		logic g;
		case (torque_cmp_timing)
			TQCH_CT_STABLE: g = stable_flag;
			TQCH_CT_NZ_OFF: g = !near_zero;
			TQCH_CT_STABLE_NZ: g = stable_flag && !near_zero;
			TQCH_CT_HOLD: g = hd;
			default: g = 1'b1;
		endcase
		if (hold && hold_mode == TQCH_HM_PEAK && v > hv) hv = v;
		if (hold && hold_mode == TQCH_HM_BOTTOM && v < hv) hv = v;
		if (g) lastj = jdg(hold ? hv : v);
		// sign mode sees the idle inverse by the time the judgement lands
		q.push_back({lastj, aux_sel_sign ? (v >= 0 && abs_marked) : (v >= timing_lo_lim && v <= timing_hi_lim)});
		m.send(v, 18'($urandom_range(0, 3000)));
		lv = v;
	endtask
	always @(posedge sys_clk) vd <= {vd[1:0], torque_valid};
	always @(negedge sys_clk) begin
		if (vd[2]) begin
			chk("judge_aux", 18'(q.pop_front()), 18'({tj_now(), aux_output_second}));
		end
	end
	function automatic logic [2:0] tj_now();
		return {torque_hi, torque_ok, torque_lo};
	endfunction
	initial begin
		#(40 * 5000);
		errors++;
		results();
	end
	// ----
	// scenarios
	// ----
	initial begin
		void'($urandom(32'h81572f00));
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		bv = '{18'sh1869f, -18'sh1869f, 18'sh003e8, 18'sh003e9, -18'sh003e8, -18'sh003e9, 18'sh007d0, -18'sh001f4};
		foreach (bv[i]) begin
			put(bv[i]);
			if (i == 1) begin
				timing_hi_lim = 18'sh007d0;
				timing_lo_lim = -18'sh001f4;
			end
		end
		for (int t = 0; t < 5; t++) begin
			repeat (6) begin
				@(negedge sys_clk);
				torque_cmp_timing = tqch_cmp_time_t'(t);
				{stable_flag, near_zero, aux_sel_sign, abs_marked, speed_cmp_sync} = 5'($urandom);
				torque_hi_lim = 18'($urandom_range(0, 3000));
				torque_lo_lim = -torque_hi_lim;
				put(18'(int'($urandom_range(0, 8000)) - 4000));
			end
		end
		foreach (hm[i]) begin
			s = (hm[i] == TQCH_HM_BOTTOM) ? -1 : 1;
			@(negedge sys_clk);
			torque_cmp_timing = TQCH_CT_HOLD;
			hold_mode = hm[i];
			aux_sel_sign = 1'b0;
			put(18'(-500 * s));
			track_hold_pin = 1'b1;
			hold = 1'b1;
			hd = 1'b1;
			hv = ~lv;
			repeat (5) @(negedge sys_clk);
			chk("hold_end", 18'(1), 18'(hold_end));
			for (int k = 1; k < 4; k++) put(18'(s * (1000 + 1000 * ((2 * k) % 3))));
			chk("held", hv, indicated_value);
			track_hold_pin = 1'b0;
			hold = 1'b0;
			hd = 1'b0;
			repeat (5) @(negedge sys_clk);
			chk("tracking", ~lv, indicated_value);
		end
		@(negedge sys_clk);
		hold_mode = TQCH_HM_PEAK;
		section_method = TQCH_SEC_LVL_TIME;
		torque_cmp_timing = TQCH_CT_ALL;
		put(-18'sh001f4);
		section_pin = 1'b1;
		hold = 1'b1;
		hv = ~lv;
		repeat (5) @(negedge sys_clk);
		chk("detect", 18'h2, 18'({hold_end, hold_decided}));
		put(18'sh00320);
		put(18'sh009c4);
		section_pin = 1'b0;
		repeat (5) @(negedge sys_clk);
		chk("decided", 18'(1), 18'(hold_decided));
		chk("held_ext", hv, indicated_value);
		track_hold_pin = 1'b1;
		repeat (3) @(negedge sys_clk);
		track_hold_pin = 1'b0;
		repeat (5) @(negedge sys_clk);
		chk("short_reset", 18'(1), 18'(hold_decided));
		track_hold_pin = 1'b1;
		repeat (12) @(negedge sys_clk);
		track_hold_pin = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk("released", 18'h0, 18'({hold_end, hold_decided}));
		results();
	end
endmodule
`default_nettype wire
